// >>> rtl/stt_map.vh
`ifndef STT_MAP_VH
`define STT_MAP_VH

// register addresses in the system control space
`define STT_ADDR_W            32
`define STT_ADDR_CTRL_STATUS  32'he000e010
`define STT_ADDR_RELOAD       32'he000e014
`define STT_ADDR_CURRENT      32'he000e018
`define STT_ADDR_CALIB        32'he000e01c

// register index codes from the address decoder
`define STT_SEL_W             3
`define STT_SEL_NONE          3'h0
`define STT_SEL_CTRL_STATUS   3'h1
`define STT_SEL_RELOAD        3'h2
`define STT_SEL_CURRENT       3'h3
`define STT_SEL_CALIB         3'h4

// data width and counter width
`define STT_DATA_W            32
`define STT_COUNT_W           24

// control/status field positions
`define STT_CSR_ENABLE_BIT    0
`define STT_CSR_IRQ_EN_BIT    1
`define STT_CSR_CLKSEL_BIT    2
`define STT_CSR_FLAG_BIT      16

// calibration field positions
`define STT_CAL_ABSENT_BIT    31
`define STT_CAL_INEXACT_BIT   30
`define STT_CAL_HINT_MSB      23
`define STT_CAL_HINT_LSB      0

// clock select encodings
`define STT_CLKSEL_REF        1'h0
`define STT_CLKSEL_CPU        1'h1

// reset values
`define STT_RST_ENABLE        1'h0
`define STT_RST_IRQ_EN        1'h0
`define STT_RST_FLAG          1'h0
`define STT_RST_COUNT         24'h000000
`define STT_RST_RELOAD        24'h000000
`define STT_RST_WORD          32'h00000000

// answer for reserved or absent locations
`define STT_RAZ_WORD          32'h00000000

// calibration defaults: 10 ms at 20 MHz is 200000 cycles, reload 199999
`define STT_TEN_MS_RELOAD     24'h030d3f

`endif

// >>> rtl/stt_ref_tick.v
`timescale 1ns/1ns
`default_nettype none

// turns the reference clock input into one-cycle count enables
module stt_ref_tick (
    input  wire clk,
    input  wire arst_n,
    input  wire ref_clk_in,
    output reg  ref_tick_q
);

    reg sync_a_q;
    reg sync_b_q;
    reg last_q;

    // two-stage synchroniser, then a rising edge detector
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_a_q   <= 1'h0;
            sync_b_q   <= 1'h0;
            last_q     <= 1'h0;
            ref_tick_q <= 1'h0;
        end else begin
            sync_a_q   <= ref_clk_in;
            sync_b_q   <= sync_a_q;
            last_q     <= sync_b_q;
            ref_tick_q <= sync_b_q & ~last_q;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/stt_down_counter.v
`timescale 1ns/1ns
`default_nettype none

// wrap-on-zero down counter with clear-to-zero
module stt_down_counter #(
    parameter COUNT_W = 24
) (
    input  wire               clk,
    input  wire               arst_n,
    input  wire               step,
    input  wire               clear,
    input  wire [COUNT_W-1:0] reload,
    output reg  [COUNT_W-1:0] count_q,
    output reg                zero_event_q
);

    localparam [COUNT_W-1:0] ZERO = {COUNT_W{1'b0}};
    localparam [COUNT_W-1:0] ONE  = {{(COUNT_W-1){1'b0}}, 1'b1};

    // clear beats a step; a zero count reloads on the next step
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q      <= ZERO;
            zero_event_q <= 1'h0;
        end else if (clear) begin
            count_q      <= ZERO;
            zero_event_q <= 1'h0;
        end else if (step) begin
            if (count_q == ZERO) begin
                count_q      <= reload;
                zero_event_q <= 1'h0;
            end else begin
                count_q      <= count_q - ONE;
                zero_event_q <= (count_q == ONE);
            end
        end else begin
            zero_event_q <= 1'h0;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/stt_timer.v
`timescale 1ns/1ns
`default_nettype none
`include "stt_map.vh"

module stt_timer #(
    parameter                    TIMER_PRESENT = 1,
    parameter                    REF_ABSENT    = 0,
    parameter                    CAL_INEXACT   = 0,
    parameter [`STT_COUNT_W-1:0] TEN_MS_HINT   = `STT_TEN_MS_RELOAD,
    parameter                    IMPL_W        = `STT_COUNT_W
) (
    input  wire                   clk,
    input  wire                   arst_n,
    input  wire                   ref_clk_in,
    input  wire                   debug_halted,
    input  wire                   reg_rd_en,
    input  wire                   reg_wr_en,
    input  wire [`STT_ADDR_W-1:0] reg_addr,
    input  wire [`STT_DATA_W-1:0] reg_wdata,
    output reg  [`STT_DATA_W-1:0] reg_rdata_q,
    output reg                    reg_rd_valid_q,
    output reg                    tick_pending_pulse_q,
    output reg                    zero_reached_flag_q
);

    localparam CW = `STT_COUNT_W;
    localparam DW = `STT_DATA_W;

    // clock select reset value follows the reference clock straps
    localparam [0:0] CLKSEL_RST = (REF_ABSENT != 0) ? `STT_CLKSEL_CPU
                                                    : `STT_CLKSEL_REF;

    // mask of implemented counter bits
    localparam [CW-1:0] IMPL_MASK = (IMPL_W >= CW) ? {CW{1'b1}}
                                  : ~({CW{1'b1}} << IMPL_W);

    // ------------------------------------------------------------
    // address decode, used by both the write and the read path
    // ------------------------------------------------------------
    function [`STT_SEL_W-1:0] decode;
        input [`STT_ADDR_W-1:0] addr;
        begin
            if (TIMER_PRESENT == 0) begin
                decode = `STT_SEL_NONE;
            end else begin
                case (addr)
                    `STT_ADDR_CTRL_STATUS: decode = `STT_SEL_CTRL_STATUS;
                    `STT_ADDR_RELOAD:      decode = `STT_SEL_RELOAD;
                    `STT_ADDR_CURRENT:     decode = `STT_SEL_CURRENT;
                    `STT_ADDR_CALIB:       decode = `STT_SEL_CALIB;
                    default:               decode = `STT_SEL_NONE;
                endcase
            end
        end
    endfunction

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    reg          enable_q;
    reg          tick_irq_enable_q;
    reg          clock_select_q;
    reg [CW-1:0] reload_q;

    wire [`STT_SEL_W-1:0] rd_sel;
    wire [`STT_SEL_W-1:0] wr_sel;
    wire                  wr_csr;
    wire                  wr_reload;
    wire                  wr_current;
    wire                  rd_csr;

    assign rd_sel     = reg_rd_en ? decode(reg_addr) : `STT_SEL_NONE;
    assign wr_sel     = reg_wr_en ? decode(reg_addr) : `STT_SEL_NONE;
    assign wr_csr     = (wr_sel == `STT_SEL_CTRL_STATUS);
    assign wr_reload  = (wr_sel == `STT_SEL_RELOAD);
    assign wr_current = (wr_sel == `STT_SEL_CURRENT);
    assign rd_csr     = (rd_sel == `STT_SEL_CTRL_STATUS);

    // control/status writes; other bits are not stored
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_q          <= `STT_RST_ENABLE;
            tick_irq_enable_q <= `STT_RST_IRQ_EN;
            clock_select_q    <= CLKSEL_RST;
        end else if (wr_csr) begin
            enable_q          <= reg_wdata[`STT_CSR_ENABLE_BIT];
            tick_irq_enable_q <= reg_wdata[`STT_CSR_IRQ_EN_BIT];
            if (REF_ABSENT == 0) begin
                clock_select_q <= reg_wdata[`STT_CSR_CLKSEL_BIT];
            end else begin
                clock_select_q <= `STT_CLKSEL_CPU;
            end
        end
    end

    // reload value; only the low IMPL_W bits, at most 24, are kept
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reload_q <= `STT_RST_RELOAD;
        end else if (wr_reload) begin
            reload_q <= reg_wdata[CW-1:0] & IMPL_MASK;
        end
    end

    // ------------------------------------------------------------
    // counting clock selection
    // ------------------------------------------------------------
    wire ref_tick;
    wire count_tick;
    wire count_step;
    wire sel_cpu;

    stt_ref_tick u_ref_tick (
        .clk        (clk),
        .arst_n     (arst_n),
        .ref_clk_in (ref_clk_in),
        .ref_tick_q (ref_tick)
    );

    // an absent reference clock always means the processor clock
    assign sel_cpu    = (REF_ABSENT != 0) |
                        (clock_select_q == `STT_CLKSEL_CPU);
    assign count_tick = sel_cpu ? 1'b1 : ref_tick;
    // enabled, ticking and not halted by the debugger
    assign count_step = enable_q & count_tick & ~debug_halted;

    // ------------------------------------------------------------
    // the counter itself
    // ------------------------------------------------------------
    wire [CW-1:0] count_raw;
    wire          zero_event;
    wire [CW-1:0] count_vis;

    // write clears regardless of data, with no read-back check
    stt_down_counter #(
        .COUNT_W (CW)
    ) u_counter (
        .clk          (clk),
        .arst_n       (arst_n),
        .step         (count_step),
        .clear        (wr_current),
        .reload       (reload_q),
        .count_q      (count_raw),
        .zero_event_q (zero_event)
    );

    // unsupported counter bits read as zero
    assign count_vis = count_raw & IMPL_MASK;

    // ------------------------------------------------------------
    // zero-reached flag: a new event wins over a clear
    // ------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            zero_reached_flag_q <= `STT_RST_FLAG;
        end else if (zero_event) begin
            zero_reached_flag_q <= 1'h1;
        end else if (rd_csr | wr_current) begin
            zero_reached_flag_q <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // exception request to the processor
    // ------------------------------------------------------------
    // only a counted 1 to 0 step raises it, never a software clear
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_pending_pulse_q <= 1'h0;
        end else begin
            tick_pending_pulse_q <= zero_event &
                                    tick_irq_enable_q;
        end
    end

    // ------------------------------------------------------------
    // read data assembly
    // ------------------------------------------------------------
    reg [DW-1:0] csr_word;
    reg [DW-1:0] reload_word;
    reg [DW-1:0] current_word;
    reg [DW-1:0] calib_word;
    reg [DW-1:0] rd_word;

    // control/status: reserved bits stay zero
    always @* begin
        csr_word                        = `STT_RST_WORD;
        csr_word[`STT_CSR_ENABLE_BIT]   = enable_q;
        csr_word[`STT_CSR_IRQ_EN_BIT]   = tick_irq_enable_q;
        csr_word[`STT_CSR_CLKSEL_BIT]   = sel_cpu;
        csr_word[`STT_CSR_FLAG_BIT]     = zero_reached_flag_q;
    end

    // reload and current value, upper byte reads zero
    always @* begin
        reload_word          = `STT_RST_WORD;
        reload_word[CW-1:0]  = reload_q;
        current_word         = `STT_RST_WORD;
        current_word[CW-1:0] = count_vis;
    end

    // calibration: fixed implementation values
    always @* begin
        calib_word                      = `STT_RST_WORD;
        calib_word[`STT_CAL_ABSENT_BIT] = (REF_ABSENT != 0);
        calib_word[`STT_CAL_INEXACT_BIT] = (CAL_INEXACT != 0);
        calib_word[`STT_CAL_HINT_MSB:`STT_CAL_HINT_LSB] =
            TEN_MS_HINT;
    end

    // select by decoded address; reserved locations read zero
    always @* begin
        case (rd_sel)
            `STT_SEL_CTRL_STATUS: rd_word = csr_word;
            `STT_SEL_RELOAD:      rd_word = reload_word;
            `STT_SEL_CURRENT:     rd_word = current_word;
            `STT_SEL_CALIB:       rd_word = calib_word;
            default:              rd_word = `STT_RAZ_WORD;
        endcase
    end

    // registered read answer, one cycle after the request
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q    <= `STT_RST_WORD;
            reg_rd_valid_q <= 1'h0;
        end else begin
            reg_rd_valid_q <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata_q <= rd_word;
            end
        end
    end

endmodule

`default_nettype wire

// >>> bench/stt_timer_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "stt_map.vh"

module stt_timer_chk #(
    parameter                    REF_ABSENT  = 0,
    parameter                    CAL_INEXACT = 0,
    parameter [`STT_COUNT_W-1:0] TEN_MS_HINT = `STT_TEN_MS_RELOAD
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        ref_clk_in,
    input wire logic        debug_halted,
    input wire logic        reg_rd_en,
    input wire logic        reg_wr_en,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata_q,
    input wire logic        reg_rd_valid_q,
    input wire logic        tick_pending_pulse_q,
    input wire logic        zero_reached_flag_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // register port answers and read layouts
    AST_RD_VALID: assert property (reg_rd_en |=> reg_rd_valid_q)
        else $error("read not answered next cycle");
    AST_CALIB: assert property (
        reg_rd_valid_q && $past(reg_addr) == `STT_ADDR_CALIB |->
        reg_rdata_q == {(REF_ABSENT != 0), (CAL_INEXACT != 0), 6'h00,
        TEN_MS_HINT}) else $error("calibration word wrong");
    AST_UPPER_ZERO: assert property (
        reg_rd_valid_q && ($past(reg_addr) == `STT_ADDR_RELOAD ||
        $past(reg_addr) == `STT_ADDR_CURRENT) |-> reg_rdata_q[31:24] == 8'h00)
        else $error("upper count bits not zero");
    AST_CSR_LAYOUT: assert property (
        reg_rd_valid_q && $past(reg_addr) == `STT_ADDR_CTRL_STATUS |->
        reg_rdata_q[31:17] == 15'h0000 && reg_rdata_q[15:3] == 13'h0000 &&
        (REF_ABSENT == 0 || reg_rdata_q[2]))
        else $error("status reserved bits set");
    AST_UNMAPPED: assert property (
        reg_rd_valid_q && !($past(reg_addr) inside
        {`STT_ADDR_CTRL_STATUS, `STT_ADDR_RELOAD, `STT_ADDR_CURRENT,
        `STT_ADDR_CALIB}) |-> reg_rdata_q == 32'h00000000)
        else $error("unmapped read not zero");
    AST_FLAG_READ: assert property (
        reg_rd_en && zero_reached_flag_q &&
        reg_addr == `STT_ADDR_CTRL_STATUS |=> reg_rdata_q[16])
        else $error("flag lost on status read");
    // pending request shape and cause
    AST_PULSE_ONE: assert property (
        tick_pending_pulse_q |=> !tick_pending_pulse_q)
        else $error("pending pulse too long");
    AST_PULSE_FLAG: assert property (
        tick_pending_pulse_q && !$past(reg_wr_en) |-> zero_reached_flag_q)
        else $error("pulse without zero flag");
    AST_CVR_NO_PULSE: assert property (
        reg_wr_en && reg_addr == `STT_ADDR_CURRENT |=> ##1
        !tick_pending_pulse_q) else $error("count clear raised pending");
    AST_DEBUG_HOLD: assert property (
        debug_halted ##1 debug_halted |=> !$rose(zero_reached_flag_q))
        else $error("counted while halted");
endmodule

bind stt_timer stt_timer_chk #(
    .REF_ABSENT (REF_ABSENT),
    .CAL_INEXACT(CAL_INEXACT),
    .TEN_MS_HINT(TEN_MS_HINT)
) u_stt_timer_chk (
    .clk(clk), .arst_n(arst_n), .ref_clk_in(ref_clk_in),
    .debug_halted(debug_halted), .reg_rd_en(reg_rd_en),
    .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_rd_valid_q(reg_rd_valid_q),
    .tick_pending_pulse_q(tick_pending_pulse_q),
    .zero_reached_flag_q(zero_reached_flag_q)
);
`default_nettype wire

// >>> bench/stt_cpu_side.sv
`timescale 1ns/1ns
`default_nettype none

module stt_cpu_side (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ref_run,
    input  wire logic        tick_pending_pulse_q,
    output var  logic        ref_clk_in,
    output var  logic [15:0] pulse_cnt,
    output var  logic [15:0] pulse_gap
);
    logic [1:0]  div_q;
    logic [15:0] since_q;

    // reference clock, 8 cycles a period, still unless running
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 2'h0;
            ref_clk_in <= 1'b0;
        end else if (ref_run) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) ref_clk_in <= ~ref_clk_in;
        end
    end

    // exception side: count pending requests and cycles between them
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_cnt <= 16'h0000;
            pulse_gap <= 16'h0000;
            since_q <= 16'h0000;
        end else if (tick_pending_pulse_q) begin
            pulse_cnt <= pulse_cnt + 16'h0001;
            pulse_gap <= since_q;
            since_q <= 16'h0001;
        end else begin
            since_q <= since_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "stt_map.vh"

module testbench;
    localparam logic [31:0] A_CSR = `STT_ADDR_CTRL_STATUS;
    localparam logic [31:0] A_RVR = `STT_ADDR_RELOAD;
    localparam logic [31:0] A_CVR = `STT_ADDR_CURRENT;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        debug_halted = 1'b0;
    logic        reg_rd_en = 1'b0;
    logic        reg_wr_en = 1'b0;
    logic        ref_run = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] rd;
    logic [15:0] cnt;
    wire  [31:0] reg_rdata_q;
    wire         reg_rd_valid_q;
    wire         tick_pending_pulse_q;
    wire         zero_reached_flag_q;
    wire         ref_clk_in;
    wire  [15:0] pulse_cnt;
    wire  [15:0] pulse_gap;
    int          errors = 0;
    int          n_tests = 0;

    always #25 clk = ~clk;

    stt_timer u_stt_timer (.clk(clk), .arst_n(arst_n),
        .ref_clk_in(ref_clk_in), .debug_halted(debug_halted),
        .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_rd_valid_q(reg_rd_valid_q),
        .tick_pending_pulse_q(tick_pending_pulse_q),
        .zero_reached_flag_q(zero_reached_flag_q));
    stt_cpu_side u_stt_cpu_side (.clk(clk), .arst_n(arst_n),
        .ref_run(ref_run), .tick_pending_pulse_q(tick_pending_pulse_q),
        .ref_clk_in(ref_clk_in), .pulse_cnt(pulse_cnt),
        .pulse_gap(pulse_gap));

    task automatic check(input string what, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle register strobes
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rdr(input logic [31:0] a);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        #1;
        check("rd_valid", 32'h1, {31'h0, reg_rd_valid_q});
        rd = reg_rdata_q;
    endtask

    task automatic t_reset;
        rdr(A_CSR); check("csr", 32'h0, rd);
        rdr(`STT_ADDR_CALIB); check("calib", 32'h00030d3f, rd);
        rdr(32'he000e020); check("unmapped", 32'h0, rd);
        wr(A_RVR, 32'hff000005);
        rdr(A_RVR); check("reload", 32'h5, rd);
        wr(A_CSR, 32'hfffefffe);
        rdr(A_CSR); check("csr_rsvd", 32'h6, rd);
    endtask

    task automatic t_count;
        wr(A_CVR, 32'hffffffff);
        wr(A_CSR, 32'h7);
        repeat (20) @(posedge clk);
        check("gap", 32'h6, {16'h0, pulse_gap});
        wr(A_CSR, 32'h6);
        wr(A_CVR, 32'h12345678);
        rdr(A_CVR); check("cvr_clr", 32'h0, rd);
    endtask

    task automatic t_noirq;
        wr(A_CSR, 32'h5);
        repeat (2) @(posedge clk);
        cnt = pulse_cnt;
        repeat (20) @(posedge clk);
        wr(A_CSR, 32'h4);
        #1;
        check("no_irq", {16'h0, cnt}, {16'h0, pulse_cnt});
        check("flag_pin", 32'h1, {31'h0, zero_reached_flag_q});
        rdr(A_CSR); check("flag_set", 32'h00010004, rd);
        check("flag_pin_clr", 32'h0, {31'h0, zero_reached_flag_q});
        rdr(A_CSR); check("flag_clr", 32'h4, rd);
    endtask

    task automatic t_hold;
        wr(A_CSR, 32'h5);
        @(posedge clk);
        debug_halted <= 1'b1;
        repeat (2) @(posedge clk);
        rdr(A_CVR); cnt = rd[15:0];
        repeat (10) @(posedge clk);
        rdr(A_CVR); check("halted", {16'h0, cnt}, rd);
        debug_halted <= 1'b0;
        wr(A_CSR, 32'h4);
        rdr(A_CVR); cnt = rd[15:0];
        repeat (10) @(posedge clk);
        rdr(A_CVR); check("disabled", {16'h0, cnt}, rd);
    endtask

    task automatic t_ref;
        ref_run <= 1'b1;
        wr(A_RVR, 32'h3);
        wr(A_CVR, 32'h0);
        wr(A_CSR, 32'h3);
        repeat (90) @(posedge clk);
        check("ref_gap", 32'h20, {16'h0, pulse_gap});
        wr(A_CSR, 32'h4);
        ref_run <= 1'b0;
    endtask

    task automatic t_zero_reload;
        wr(A_RVR, 32'h0);
        wr(A_CVR, 32'h0);
        wr(A_CSR, 32'h7);
        cnt = pulse_cnt;
        repeat (20) @(posedge clk);
        rdr(A_CVR); check("stuck", 32'h0, rd);
        check("no_wrap", {16'h0, cnt}, {16'h0, pulse_cnt});
    endtask

    // mid-run reset while counting puts every register back
    task automatic t_rst;
        wr(A_RVR, 32'h9);
        wr(A_CSR, 32'h7);
        repeat (12) @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        check("rst_flag", 32'h0, {31'h0, zero_reached_flag_q});
        rdr(A_CSR); check("rst_csr", 32'h0, rd);
        rdr(A_RVR); check("rst_rvr", 32'h0, rd);
        rdr(A_CVR); check("rst_cvr", 32'h0, rd);
    endtask

    task automatic report_and_stop;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_count();
        t_noirq();
        t_hold();
        t_ref();
        t_zero_reload();
        t_rst();
        report_and_stop();
    end
endmodule
`default_nettype wire
